/* hw/eth_status_irq.sv */
// status flags and interrupt enable for the ethernet mac and its dma engine
// assumes event inputs are one-cycle pulses synchronous to clk_i,
// upper status bits and the core status summary arrive as levels
//
// Behaviour
// - set bit 10 when carrier is lost during transmission
// - set bit 9 when a collision occurs during transmission
// - set bit 8 after 16 failed attempts since transmission start
// - set bit 7 on reception of a multicast-addressed frame
// - set bit 5 when a drop request cannot be served by dma
// - set bit 4 on a received frame with leftover bits
// - set bit 3 on a received frame of 1519 bytes or more
// - set bit 2 on a received frame under 64 bytes
// - set bit 1 on a transceiver receive error
// - set bit 0 on a received frame failing crc
// - enable register has one enable per flag, same position
// - enable one lets the flag interrupt; zero blocks it
// - all enables clear after reset
// - enable bits 31..25 read zero, ignore writes
// - enable bits 23, 15..13 and 6 read zero
// - enable bit 24 gates the frame counter overflow flag
// - core status bit 22 follows its source, clearing with it
`timescale 1ns/1ns
module eth_status_irq (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic write_i,
  input wire logic read_i,
  output logic [31:0] rdata_o,
  input wire logic tx_start_i,
  input wire logic carrier_lost_i,
  input wire logic collision_i,
  input wire logic tx_attempt_fail_i,
  input wire logic rx_frame_done_i,
  input wire logic [15:0] rx_byte_count_i,
  input wire logic rx_partial_byte_i,
  input wire logic rx_group_addr_i,
  input wire logic rx_checksum_bad_i,
  input wire logic drop_request_i,
  input wire logic drop_possible_i,
  input wire logic transceiver_error_i,
  input wire logic [31:0] upper_status_i,
  input wire logic core_status_pending_i,
  output logic irq_o
);
  flag_bank_if fb();

  flag_bank u_flags (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .fb(fb.bank)
  );

  logic [31:0] enable;
  logic [31:0] next_enable;
  logic [31:0] rdata;
  logic [31:0] next_rdata;
  logic irq;
  logic next_irq;
  logic [4:0] tries;
  logic [4:0] next_tries;
  logic retry_hit;
  logic [10:0] set_vec;
  logic [10:0] clr_vec;
  logic [31:0] status_word;
  logic [31:0] pending;

  // merge old value and write data under a mask
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] val,
                                        input logic [31:0] mask);
    merge = (old & ~mask) | (val & mask);
  endfunction

  // pulse qualified by a completed receive frame
  function automatic logic rx_event(input logic done, input logic cond);
    rx_event = done & cond;
  endfunction

  // failed attempt counter, restarted by each transmission start
  always_comb begin
    next_tries = tries;
    retry_hit = 1'b0;
    if (tx_start_i) begin
      next_tries = 5'h00;
    end else if (tx_attempt_fail_i && tries != eth_irq_pkg::TX_ATTEMPTS) begin
      next_tries = tries + 5'h01;
      retry_hit = (tries + 5'h01) == eth_irq_pkg::TX_ATTEMPTS;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      tries <= 5'h00;
    end else begin
      tries <= next_tries;
    end
  end

  // set requests for the low status flags
  always_comb begin
    set_vec = 11'h000;
    set_vec[eth_irq_pkg::BIT_CARRIER_LOST] = carrier_lost_i;
    set_vec[eth_irq_pkg::BIT_COLLISION] = collision_i;
    set_vec[eth_irq_pkg::BIT_RETRY] = retry_hit;
    set_vec[eth_irq_pkg::BIT_GROUP_ADDR] = rx_event(rx_frame_done_i, rx_group_addr_i);
    set_vec[eth_irq_pkg::BIT_DROP_UNSERVED] = drop_request_i & ~drop_possible_i;
    set_vec[eth_irq_pkg::BIT_PARTIAL] = rx_event(rx_frame_done_i, rx_partial_byte_i);
    set_vec[eth_irq_pkg::BIT_OVERSIZE] = rx_event(rx_frame_done_i,
      rx_byte_count_i >= eth_irq_pkg::LONG_FRAME_BYTES);
    set_vec[eth_irq_pkg::BIT_UNDERSIZE] = rx_event(rx_frame_done_i,
      rx_byte_count_i < eth_irq_pkg::SHORT_FRAME_BYTES);
    set_vec[eth_irq_pkg::BIT_XCVR_ERR] = transceiver_error_i;
    set_vec[eth_irq_pkg::BIT_CHECKSUM] = rx_event(rx_frame_done_i, rx_checksum_bad_i);
  end

  // write one to clear; reserved bit 6 is masked off
  always_comb begin
    clr_vec = 11'h000;
    if (write_i && addr_i == eth_irq_pkg::OFS_STATUS) begin
      clr_vec = wdata_i[10:0] & eth_irq_pkg::LOW_MASK;
    end
  end

  assign fb.set = set_vec;
  assign fb.clr = clr_vec;

  // full status word; core status bit tracks its source directly
  always_comb begin
    status_word = upper_status_i & eth_irq_pkg::UPPER_MASK;
    status_word[eth_irq_pkg::BIT_CORE_STATUS] = core_status_pending_i;
    status_word[10:0] = fb.flags;
  end

  assign pending = status_word & enable;

  // register port, enable register and interrupt output
  always_comb begin
    next_enable = enable;
    if (write_i && addr_i == eth_irq_pkg::OFS_ENABLE) begin
      next_enable = merge(enable, wdata_i, eth_irq_pkg::ENABLE_MASK);
    end
    next_rdata = 32'h00000000;
    if (read_i) begin
      case (addr_i)
        eth_irq_pkg::OFS_STATUS: next_rdata = status_word;
        eth_irq_pkg::OFS_ENABLE: next_rdata = enable;
        default: next_rdata = 32'h00000000;
      endcase
    end
    next_irq = |pending;
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      enable <= eth_irq_pkg::ENABLE_RESET;
      rdata <= 32'h00000000;
      irq <= 1'b0;
    end else begin
      enable <= next_enable;
      rdata <= next_rdata;
      irq <= next_irq;
    end
  end

  assign rdata_o = rdata;
  assign irq_o = irq;

  chk_carrier_sets: assert property (@(posedge clk_i) disable iff (rst_i)
    carrier_lost_i |=> fb.flags[10])
    else $error("carrier loss did not set bit 10");
  chk_collision_sets: assert property (@(posedge clk_i) disable iff (rst_i)
    collision_i |=> fb.flags[9])
    else $error("collision did not set bit 9");
  chk_collision_sticky: assert property (@(posedge clk_i) disable iff (rst_i)
    (fb.flags[9] && !clr_vec[9]) |=> fb.flags[9])
    else $error("collision flag dropped without a clear");
  chk_retry_count: assert property (@(posedge clk_i) disable iff (rst_i)
    (!fb.flags[8] && !tx_start_i && tx_attempt_fail_i && tries == 5'h0F) |=> fb.flags[8])
    else $error("sixteenth failed attempt did not set bit 8");
  chk_retry_early: assert property (@(posedge clk_i) disable iff (rst_i)
    (!fb.flags[8] && tries < 5'h0F && !clr_vec[8]) |=> !fb.flags[8])
    else $error("retry flag set before sixteen attempts");
  chk_retry_restart: assert property (@(posedge clk_i) disable iff (rst_i)
    tx_start_i |=> tries == 5'h00)
    else $error("transmission start did not restart the attempt count");
  chk_group_sets: assert property (@(posedge clk_i) disable iff (rst_i)
    (rx_frame_done_i && rx_group_addr_i) |=> fb.flags[7])
    else $error("multicast frame did not set bit 7");
  chk_drop_sets: assert property (@(posedge clk_i) disable iff (rst_i)
    (drop_request_i && !drop_possible_i) |=> fb.flags[5])
    else $error("unserved drop request did not set bit 5");
  chk_partial_sets: assert property (@(posedge clk_i) disable iff (rst_i)
    (rx_frame_done_i && rx_partial_byte_i) |=> fb.flags[4])
    else $error("residual bit frame did not set bit 4");
  chk_oversize_sets: assert property (@(posedge clk_i) disable iff (rst_i)
    (rx_frame_done_i && rx_byte_count_i == 16'h05EF) |=>
      fb.flags[3] && (!fb.flags[2] || $past(fb.flags[2])))
    else $error("1519-byte frame mishandled");
  chk_oversize_edge: assert property (@(posedge clk_i) disable iff (rst_i)
    (rx_frame_done_i && rx_byte_count_i == 16'h05EE && !fb.flags[3]) |=> !fb.flags[3])
    else $error("1518-byte frame set bit 3");
  chk_undersize_sets: assert property (@(posedge clk_i) disable iff (rst_i)
    (rx_frame_done_i && rx_byte_count_i == 16'h003F) |=> fb.flags[2])
    else $error("63-byte frame did not set bit 2");
  chk_undersize_edge: assert property (@(posedge clk_i) disable iff (rst_i)
    (rx_frame_done_i && rx_byte_count_i == 16'h0040 && !fb.flags[2]) |=> !fb.flags[2])
    else $error("64-byte frame set bit 2");
  chk_xcvr_sets: assert property (@(posedge clk_i) disable iff (rst_i)
    transceiver_error_i |=> fb.flags[1])
    else $error("transceiver error did not set bit 1");
  chk_crc_sets: assert property (@(posedge clk_i) disable iff (rst_i)
    (rx_frame_done_i && rx_checksum_bad_i) |=> fb.flags[0])
    else $error("crc failure did not set bit 0");
  chk_enable_write: assert property (@(posedge clk_i) disable iff (rst_i)
    (write_i && addr_i == eth_irq_pkg::OFS_ENABLE) |=>
      enable == ($past(wdata_i) & 32'h017F1FBF))
    else $error("enable write did not land on the writable bits");
  chk_reset_clears: assert property (@(posedge clk_i)
    rst_i |=> (enable == 32'h00000000 && !irq_o))
    else $error("reset left an enable or the interrupt set");
  chk_enable_reserved: assert property (@(posedge clk_i) disable iff (rst_i)
    (enable & ~32'h017F1FBF) == 32'h00000000)
    else $error("reserved enable bit became set");
  chk_read_zeros: assert property (@(posedge clk_i) disable iff (rst_i)
    (read_i && addr_i == eth_irq_pkg::OFS_ENABLE) |=> (rdata_o & 32'hFE80E040) == 32'h00000000)
    else $error("reserved enable bit read as one");
  chk_irq_follows: assert property (@(posedge clk_i) disable iff (rst_i)
    ##1 irq_o == |($past(status_word) & $past(enable)))
    else $error("interrupt does not follow enabled flags");
  chk_core_follows: assert property (@(posedge clk_i) disable iff (rst_i)
    (read_i && addr_i == 8'h00) |=> rdata_o[22] == $past(core_status_pending_i))
    else $error("core status bit does not follow its source");
  chk_enable_gate: assert property (@(posedge clk_i) disable iff (rst_i)
    (status_word[24] && (pending & 32'hFEFFFFFF) == 32'h00000000) |=>
      irq_o == $past(enable[24]))
    else $error("counter overflow interrupt does not follow its enable");

  cov_irq_raise: cover property (@(posedge clk_i) disable iff (rst_i) $rose(irq_o));
  cov_retry_over: cover property (@(posedge clk_i) disable iff (rst_i) retry_hit);
  cov_set_clear: cover property (@(posedge clk_i) disable iff (rst_i)
    set_vec[0] && clr_vec[0]);
  cov_core_irq: cover property (@(posedge clk_i) disable iff (rst_i) pending[22]);
  cov_retry_irq: cover property (@(posedge clk_i) disable iff (rst_i) pending[8]);
endmodule

/* hw/eth_irq_pkg.sv */
// constants for the ethernet status flags and interrupt enable block
// assumes a 32-bit register port and one system clock
package eth_irq_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int LOW_W = 11;
  localparam int LEN_W = 16;
  localparam int TRY_W = 5;

  // register offsets (byte addresses)
  localparam logic [7:0] OFS_STATUS = 8'h00;
  localparam logic [7:0] OFS_ENABLE = 8'h04;

  // reset values
  localparam logic [31:0] ENABLE_RESET = 32'h00000000;
  localparam logic [10:0] FLAGS_RESET = 11'h000;

  // writable enable bits: 24, 22..16, 12..7, 5..0
  localparam logic [31:0] ENABLE_MASK = 32'h017F1FBF;
  // status bits held in this block: 10..7, 5..0
  localparam logic [10:0] LOW_MASK = 11'h7BF;
  // status bits supplied as levels by the rest of the controller
  localparam logic [31:0] UPPER_MASK = 32'h017F1800;

  // status bit positions
  localparam int BIT_CHECKSUM = 0;
  localparam int BIT_XCVR_ERR = 1;
  localparam int BIT_UNDERSIZE = 2;
  localparam int BIT_OVERSIZE = 3;
  localparam int BIT_PARTIAL = 4;
  localparam int BIT_DROP_UNSERVED = 5;
  localparam int BIT_GROUP_ADDR = 7;
  localparam int BIT_RETRY = 8;
  localparam int BIT_COLLISION = 9;
  localparam int BIT_CARRIER_LOST = 10;
  localparam int BIT_CORE_STATUS = 22;
  localparam int BIT_FRAME_CNT_OVF = 24;

  // frame length limits in bytes
  localparam logic [15:0] LONG_FRAME_BYTES = 16'h05EF;
  localparam logic [15:0] SHORT_FRAME_BYTES = 16'h0040;
  // first try plus back-off retries
  localparam logic [4:0] TX_ATTEMPTS = 5'h10;
endpackage

/* hw/flag_bank_if.sv */
// set, clear and state of the low status flags
// assumes one driver per direction, shared system clock
`timescale 1ns/1ns
interface flag_bank_if;
  logic [10:0] set;
  logic [10:0] clr;
  logic [10:0] flags;
  modport bank(input set, input clr, output flags);
  modport user(output set, output clr, input flags);
endinterface

/* hw/flag_bank.sv */
// sticky status flags: hardware sets, software clears by writing one
// assumes set and clear are single-cycle requests on clk_i
`timescale 1ns/1ns
module flag_bank (
  input wire logic clk_i,
  input wire logic rst_i,
  flag_bank_if.bank fb
);
  logic [10:0] flags;
  logic [10:0] next_flags;

  // set wins over a clear in the same cycle; reserved bit never sets
  always_comb begin
    next_flags = ((flags & ~fb.clr) | fb.set) & eth_irq_pkg::LOW_MASK;
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      flags <= eth_irq_pkg::FLAGS_RESET;
    end else begin
      flags <= next_flags;
    end
  end

  assign fb.flags = flags;

  chk_set_wins: assert property (@(posedge clk_i) disable iff (rst_i)
    (fb.set[0] && fb.clr[0]) |=> flags[0])
    else $error("flag clear beat a simultaneous set");
  chk_reserved_six: assert property (@(posedge clk_i) disable iff (rst_i)
    !flags[6])
    else $error("reserved status bit 6 became set");
endmodule

/* testbench/sw_master.sv */
// software side model: register writes and reads over the plain port
// assumes read data stands in the cycle after the read strobe
`timescale 1ns/1ns
module sw_master (
  input wire logic clk_i,
  output logic [7:0] addr_o,
  output logic [31:0] wdata_o,
  output logic write_o,
  output logic read_o,
  input wire logic [31:0] rdata_i
);
  // idle cycles before each access, for a slow processor
  int gap = 0;
  initial begin
    addr_o = 8'h00;
    wdata_o = 32'h00000000;
    write_o = 1'b0;
    read_o = 1'b0;
  end
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    repeat (gap) @(posedge clk_i);
    @(posedge clk_i);
    addr_o <= a;
    // the reserved status position is always written as zero
    wdata_o <= (a == eth_irq_pkg::OFS_STATUS) ? (d & 32'hFFFFFFBF) : d;
    write_o <= 1'b1;
    @(posedge clk_i);
    write_o <= 1'b0;
    wdata_o <= ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    repeat (gap) @(posedge clk_i);
    @(posedge clk_i);
    addr_o <= a;
    read_o <= 1'b1;
    @(posedge clk_i);
    read_o <= 1'b0;
    #1;
    d = rdata_i;
  endtask
endmodule

/* testbench/eth_status_irq_tb.sv */
// self-checking bench for the status flags and interrupt enable block
// assumes one 125 MHz clock and the software model driving the register port
`timescale 1ns/1ns
module eth_status_irq_tb;
  localparam logic [7:0] ST = eth_irq_pkg::OFS_STATUS;
  localparam logic [7:0] EN = eth_irq_pkg::OFS_ENABLE;
  localparam logic [31:0] WR_MASK = 32'h017F1FBF;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [7:0] addr;
  logic [31:0] wdata, rdata, rv, v;
  logic [31:0] upper = 32'h00000000;
  logic [31:0] seed = 32'h0001677E;
  logic wr, rd, irq;
  logic core = 1'b0, start = 1'b0, fail = 1'b0, can_drop = 1'b1;
  logic [10:0] ev = 11'h000;
  logic [15:0] len = 16'h0064;
  int failures = 0, n_compared = 0;
  logic [31:0] exp_st = 32'h00000000, exp_en = 32'h00000000;
  int kinds[9] = '{0, 1, 2, 3, 4, 5, 7, 9, 10};
  int bounds[4] = '{63, 64, 1518, 1519};
  int l;

  always #4 clk_i = ~clk_i;

  sw_master i_sw_master (.clk_i(clk_i), .addr_o(addr), .wdata_o(wdata), .write_o(wr),
    .read_o(rd), .rdata_i(rdata));
  eth_status_irq i_eth_status_irq (.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr),
    .wdata_i(wdata), .write_i(wr), .read_i(rd), .rdata_o(rdata), .tx_start_i(start),
    .carrier_lost_i(ev[10]), .collision_i(ev[9]), .tx_attempt_fail_i(fail),
    .rx_frame_done_i(ev[0] | ev[2] | ev[3] | ev[4] | ev[6] | ev[7]),
    .rx_byte_count_i(len), .rx_partial_byte_i(ev[4]), .rx_group_addr_i(ev[7]),
    .rx_checksum_bad_i(ev[0]), .drop_request_i(ev[5]), .drop_possible_i(can_drop),
    .transceiver_error_i(ev[1]), .upper_status_i(upper), .core_status_pending_i(core),
    .irq_o(irq));

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [31:0] st_now();
    return exp_st | (upper & 32'h013F1800) | {9'h000, core, 22'h000000};
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic verify();
    i_sw_master.rd(ST, rv);
    check(rv, st_now());
    check({31'h00000000, irq}, {31'h00000000, |(st_now() & exp_en)});
  endtask
  task automatic set_en(input logic [31:0] d);
    i_sw_master.wr(EN, d);
    exp_en = d & WR_MASK;
  endtask
  task automatic clear_all();
    i_sw_master.wr(ST, exp_st);
    exp_st = 32'h00000000;
    verify();
  endtask
  task automatic pulse(input int k);
    @(posedge clk_i);
    ev <= 11'h001 << k;
    @(posedge clk_i);
    ev <= 11'h000;
  endtask
  task automatic fails(input int n);
    repeat (n) begin
      @(posedge clk_i) fail <= 1'b1;
      @(posedge clk_i) fail <= 1'b0;
    end
  endtask
  task automatic report_and_stop();
    $display("compared %0d, failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  initial begin
    #100000;
    failures++;
    report_and_stop();
  end

  initial begin
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    i_sw_master.rd(EN, rv);
    check(rv, 32'h00000000);
    @(posedge clk_i);
    #1 check(rdata, 32'h00000000);
    set_en(32'hFFFFFFFF);
    i_sw_master.rd(EN, rv);
    check(rv, WR_MASK);
    i_sw_master.rd(8'h08, rv);
    check(rv, 32'h00000000);
    foreach (kinds[i]) begin
      len <= (kinds[i] == 2) ? 16'h000A : (kinds[i] == 3) ? 16'h07D0 : 16'h0064;
      can_drop <= (kinds[i] != 5);
      pulse(kinds[i]);
      exp_st = 32'h00000001 << kinds[i];
      verify();
      clear_all();
    end
    can_drop <= 1'b1;
    pulse(5);
    verify();
    set_en(32'h00000000);
    pulse(9);
    exp_st = 32'h00000200;
    verify();
    set_en(32'h00000200);
    verify();
    clear_all();
    // crc event and its clear in the same cycle: the set must win
    fork
      pulse(0);
      i_sw_master.wr(ST, 32'h00000001);
    join
    exp_st = 32'h00000001;
    verify();
    clear_all();
    @(posedge clk_i) start <= 1'b1;
    @(posedge clk_i) start <= 1'b0;
    fails(15);
    verify();
    fails(1);
    exp_st = 32'h00000100;
    set_en(32'h00000100);
    verify();
    clear_all();
    set_en(32'h0000000C);
    for (int i = 0; i < 24; i++) begin
      l = (i < 4) ? bounds[i] : int'(xs() % 3000);
      len <= l[15:0];
      pulse(6);
      exp_st = {28'h0000000, (l >= 1519), (l < 64), 2'b00};
      verify();
      clear_all();
    end
    i_sw_master.gap = 2;
    repeat (6) begin
      v = xs();
      set_en(v);
      i_sw_master.rd(EN, rv);
      check(rv, v & WR_MASK);
    end
    i_sw_master.gap = 0;
    upper <= 32'h01000000;
    set_en(32'h01000000);
    verify();
    set_en(32'h00000000);
    verify();
    upper <= 32'h00000000;
    core <= 1'b1;
    set_en(32'h00400000);
    verify();
    core <= 1'b0;
    verify();
    // reset in mid-run drops enables, flags and the interrupt
    set_en(32'hFFFFFFFF);
    pulse(9);
    exp_st = 32'h00000200;
    verify();
    @(posedge clk_i) rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    exp_st = 32'h00000000;
    exp_en = 32'h00000000;
    i_sw_master.rd(EN, rv);
    check(rv, 32'h00000000);
    verify();
    report_and_stop();
  end
endmodule
